// >>> design/uart_mp_pkg.sv
// Shared constants, register map and carrier types for the multi-drop serial port
package uart_mp_pkg;
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFF_DATA = 3'h0;
    localparam logic [2:0] OFF_CSA = 3'h1;
    localparam logic [2:0] OFF_CB = 3'h2;
    localparam logic [2:0] OFF_CC = 3'h3;
    localparam logic [2:0] OFF_BAUD = 3'h4;

    // Field positions in ctrl_status_a
    localparam int CSA_RXC = 7;
    localparam int CSA_TXC = 6;
    localparam int CSA_U2X = 1;
    localparam int CSA_MPCM = 0;
    // Field positions in ctrl_b
    localparam int CB_RXCIE = 7;
    localparam int CB_TXCIE = 6;
    localparam int CB_UDRIE = 5;
    localparam int CB_RXEN = 4;
    localparam int CB_TXEN = 3;
    localparam int CB_SIZE2 = 2;
    localparam int CB_TX9 = 0;
    // Field positions in ctrl_c
    localparam int CC_MODE0 = 6;
    localparam int CC_PAR_EN = 5;
    localparam int CC_PAR_ODD = 4;
    localparam int CC_TWO_STOP = 3;

    localparam logic [7:0] RST_CC = 8'h06;
    localparam logic [7:0] RST_BAUD = 8'h00;
    localparam logic [2:0] SIZE_NINE = 3'h7;
    localparam logic [4:0] OS_NORMAL = 5'h10;
    localparam logic [4:0] OS_DOUBLE = 5'h08;
    localparam int FIFO_DEPTH = 2;

    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic fe;
        logic upe;
    } rx_entry_s;

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_e;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2} tx_state_e;
endpackage : uart_mp_pkg

// >>> design/rx_fifo.sv
// Small receive FIFO with registered head entry
`timescale 1ns/1ps
module rx_fifo
    import uart_mp_pkg::*;
#(
    parameter int WIDTH = $bits(rx_entry_s),
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] head_q,
    output logic full,
    output logic empty
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("rx_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic do_pop;
    logic do_push;
    logic [CW-1:0] left_after_pop;
    logic [WIDTH-1:0] head_d;

    // Push refused when full unless a pop frees a slot this cycle
    assign do_pop = pop && !empty;
    assign do_push = push && (!full || do_pop);
    assign full = (count_q == CW'(DEPTH));
    assign empty = (count_q == '0);
    assign left_after_pop = count_q - CW'(do_pop);
    assign head_d = (left_after_pop == '0) ? (do_push ? push_data : '0) : mem_q[PW'(rd_ptr_q + PW'(do_pop))];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            head_q <= '0;
        end else if (flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            head_q <= '0;
        end else begin
            wr_ptr_q <= PW'(wr_ptr_q + PW'(do_push));
            rd_ptr_q <= PW'(rd_ptr_q + PW'(do_pop));
            count_q <= CW'(left_after_pop + CW'(do_push));
            head_q <= head_d;
        end
    end

    // Storage has no reset; validity is carried by the count
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= push_data;
        end
    end
endmodule : rx_fifo

// >>> design/uart_mp.sv
// Serial port with data window, status flags and address-filter receive
`timescale 1ns/1ps
module uart_mp
    import uart_mp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data_q,
    input wire logic rx_line,
    output logic tx_line_q,
    input wire logic global_irq_en,
    input wire logic tx_irq_ack,
    output logic rx_irq_q,
    output logic tx_irq_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Control registers
    logic u2x_q, mpcm_q, txc_q;
    logic rxcie_q, txcie_q, udrie_q, rxen_q, txen_q, size2_q, tx9_q;
    logic [7:0] ctrl_c_q;
    logic [7:0] baud_q;
    logic [7:0] baud_cnt_q;
    logic dor_q;

    // Bus decode
    logic wr_data_win, wr_csa, wr_cb, wr_cc, wr_baud, rd_data_win;
    assign wr_data_win = wr_en && (addr == OFF_DATA);
    assign rd_data_win = rd_en && (addr == OFF_DATA);
    assign wr_csa = wr_en && (addr == OFF_CSA);
    assign wr_cb = wr_en && (addr == OFF_CB);
    assign wr_cc = wr_en && (addr == OFF_CC);
    assign wr_baud = wr_en && (addr == OFF_BAUD);

    // Frame format
    logic [2:0] size_code;
    logic nine_bit;
    logic [3:0] nbits;
    logic [8:0] data_mask;
    logic async_mode;
    logic [4:0] os_last, os_c, os_c1, os_c2;
    assign size_code = {size2_q, ctrl_c_q[2:1]};
    assign nine_bit = (size_code == SIZE_NINE);
    assign nbits = nine_bit ? 4'h9 : (size_code[2] ? 4'h8 : 4'(4'h5 + {2'b00, size_code[1:0]}));
    assign data_mask = 9'((10'h001 << nbits) - 10'h001);
    assign async_mode = (ctrl_c_q[7:6] == 2'b00);
    assign os_last = (async_mode && u2x_q) ? OS_DOUBLE : OS_NORMAL;
    assign os_c = {1'b0, os_last[4:1]};
    assign os_c1 = 5'(os_c + 5'h01);
    assign os_c2 = 5'(os_c + 5'h02);

    // Oversampling enable from the baud divider
    logic os_tick;
    assign os_tick = (baud_cnt_q == 8'h00);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            baud_cnt_q <= 8'h00;
        end else begin
            baud_cnt_q <= (os_tick || wr_baud) ? baud_q : 8'(baud_cnt_q - 8'h01);
        end
    end

    // Receive pin: three stages, level moves only when stages two and three agree
    logic rx_meta_q, rx_s2_q, rx_s3_q, rx_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
            rx_q <= 1'b1;
        end else begin
            rx_meta_q <= rx_line;
            rx_s2_q <= rx_meta_q;
            rx_s3_q <= rx_s2_q;
            rx_q <= (rx_s2_q == rx_s3_q) ? rx_s3_q : rx_q;
        end
    end

    // Receiver
    rx_state_e rx_state_q, rx_state_d;
    logic [4:0] rx_smp_q, rx_smp_d, rx_cur;
    logic [1:0] rx_vote_q, rx_vote_d;
    logic [3:0] rx_idx_q, rx_idx_d;
    logic [8:0] rx_sh_q, rx_sh_d;
    logic rx_par_q, rx_par_d;
    logic maj, rx_done, start_seen;
    assign rx_cur = (rx_smp_q == os_last) ? 5'h01 : 5'(rx_smp_q + 5'h01);
    assign maj = (rx_vote_q[1] & rx_vote_q[0]) | (rx_vote_q[1] & rx_q) | (rx_vote_q[0] & rx_q);
    assign start_seen = os_tick && rxen_q && (rx_state_q == RX_IDLE) && !rx_q;

    always_comb begin
        rx_state_d = rx_state_q;
        rx_smp_d = rx_smp_q;
        rx_vote_d = rx_vote_q;
        rx_idx_d = rx_idx_q;
        rx_sh_d = rx_sh_q;
        rx_par_d = rx_par_q;
        rx_done = 1'b0;
        if (!rxen_q) begin
            rx_state_d = RX_IDLE;
        end else if (os_tick) begin
            if (rx_state_q == RX_IDLE) begin
                if (!rx_q) begin
                    rx_state_d = RX_START;
                    rx_smp_d = 5'h01;
                    rx_sh_d = 9'h000;
                    rx_idx_d = 4'h0;
                end
            end else begin
                rx_smp_d = rx_cur;
                if (rx_cur == os_c || rx_cur == os_c1) begin
                    rx_vote_d = {rx_vote_q[0], rx_q};
                end
                if (rx_cur == os_c2) begin
                    case (rx_state_q)
                        RX_START: rx_state_d = maj ? RX_IDLE : RX_START;
                        RX_DATA: rx_sh_d[rx_idx_q] = maj;
                        RX_PARITY: rx_par_d = maj;
                        RX_STOP: begin
                            rx_done = 1'b1;
                            rx_state_d = RX_IDLE;
                        end
                        default: rx_state_d = RX_IDLE;
                    endcase
                end
                if (rx_smp_q == os_last) begin
                    case (rx_state_q)
                        RX_START: rx_state_d = RX_DATA;
                        RX_DATA: begin
                            rx_idx_d = 4'(rx_idx_q + 4'h1);
                            if (rx_idx_q == 4'(nbits - 4'h1)) begin
                                rx_state_d = ctrl_c_q[CC_PAR_EN] ? RX_PARITY : RX_STOP;
                            end
                        end
                        RX_PARITY: rx_state_d = RX_STOP;
                        default: rx_state_d = rx_state_q;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_q <= RX_IDLE;
            rx_smp_q <= 5'h00;
            rx_vote_q <= 2'b11;
            rx_idx_q <= 4'h0;
            rx_sh_q <= 9'h000;
            rx_par_q <= 1'b0;
        end else begin
            rx_state_q <= rx_state_d;
            rx_smp_q <= rx_smp_d;
            rx_vote_q <= rx_vote_d;
            rx_idx_q <= rx_idx_d;
            rx_sh_q <= rx_sh_d;
            rx_par_q <= rx_par_d;
        end
    end

    // Completed frame: type, errors, filter
    rx_entry_s done_ent, pend_ent_q, push_ent, head;
    logic frame_type, done_ok, pend_q, fifo_full, fifo_empty, space, push, pop;
    localparam int WIDTHX = $bits(rx_entry_s);
    logic [WIDTHX-1:0] head_raw;
    assign frame_type = nine_bit ? rx_sh_q[8] : maj;
    assign done_ent.data = rx_sh_q[7:0];
    assign done_ent.ninth = rx_sh_q[8];
    assign done_ent.fe = !maj;
    assign done_ent.upe = ctrl_c_q[CC_PAR_EN] && (rx_par_q != (ctrl_c_q[CC_PAR_ODD] ^ (^rx_sh_q)));
    // Address frames (type one) pass; data frames drop while filtering
    assign done_ok = rx_done && (!mpcm_q || frame_type);
    assign pop = rd_data_win;
    assign space = !fifo_full || (pop && !fifo_empty);
    assign push = space && (pend_q || done_ok);
    assign push_ent = pend_q ? pend_ent_q : done_ent;
    assign head = rx_entry_s'(head_raw);

    // A finished frame waits here when both entries are occupied
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
            pend_ent_q <= '0;
        end else if (!rxen_q) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= done_ok ? (pend_q || !space) : (pend_q && !space);
            if (done_ok && (pend_q || !space)) begin
                pend_ent_q <= done_ent;
            end
        end
    end

    rx_fifo #(
        .WIDTH(WIDTHX),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(!rxen_q),
        .push(push && rxen_q),
        .push_data(push_ent),
        .pop(pop),
        .head_q(head_raw),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    // Overrun: a new start while both entries and the shifter are occupied
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dor_q <= 1'b0;
        end else if (!rxen_q) begin
            dor_q <= 1'b0;
        end else if (start_seen && fifo_full && pend_q) begin
            dor_q <= 1'b1;
        end else if (pop) begin
            dor_q <= 1'b0;
        end
    end

    // Transmitter: holding buffer and shifter, independent of the filter bit
    logic tx_hold_full_q;
    logic [8:0] tx_hold_q;
    tx_state_e tx_state_q, tx_state_d;
    logic [4:0] tx_smp_q;
    logic [3:0] tx_idx_q;
    logic [8:0] tx_sh_q;
    logic tx_par_q, tx_load, tx_end, tx_bit_end, txc_set, tx_line_d;
    assign tx_load = txen_q && tx_hold_full_q && (tx_state_q == TX_IDLE || tx_end);
    assign tx_bit_end = os_tick && (tx_smp_q == os_last);
    assign tx_end = tx_bit_end && ((tx_state_q == TX_STOP2) || (tx_state_q == TX_STOP1 && !ctrl_c_q[CC_TWO_STOP]));
    assign txc_set = tx_end && !tx_hold_full_q;

    always_comb begin
        tx_state_d = tx_state_q;
        if (tx_load) begin
            tx_state_d = TX_START;
        end else if (tx_bit_end) begin
            case (tx_state_q)
                TX_START: tx_state_d = TX_DATA;
                TX_DATA: begin
                    if (tx_idx_q == 4'(nbits - 4'h1)) begin
                        tx_state_d = ctrl_c_q[CC_PAR_EN] ? TX_PARITY : TX_STOP1;
                    end
                end
                TX_PARITY: tx_state_d = TX_STOP1;
                TX_STOP1: tx_state_d = ctrl_c_q[CC_TWO_STOP] ? TX_STOP2 : TX_IDLE;
                TX_STOP2: tx_state_d = TX_IDLE;
                default: tx_state_d = TX_IDLE;
            endcase
        end
        case (tx_state_q)
            TX_START: tx_line_d = 1'b0;
            TX_DATA: tx_line_d = tx_sh_q[tx_idx_q];
            TX_PARITY: tx_line_d = tx_par_q;
            default: tx_line_d = 1'b1;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_hold_full_q <= 1'b0;
            tx_hold_q <= 9'h000;
        end else if (wr_data_win && !tx_hold_full_q) begin
            tx_hold_full_q <= 1'b1;
            tx_hold_q <= {tx9_q, wr_data};
        end else if (tx_load) begin
            tx_hold_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_q <= TX_IDLE;
            tx_smp_q <= 5'h01;
            tx_idx_q <= 4'h0;
            tx_sh_q <= 9'h000;
            tx_par_q <= 1'b0;
            tx_line_q <= 1'b1;
        end else begin
            tx_state_q <= tx_state_d;
            tx_line_q <= tx_line_d;
            if (tx_load) begin
                tx_smp_q <= 5'h01;
                tx_idx_q <= 4'h0;
                tx_sh_q <= tx_hold_q & data_mask;
                tx_par_q <= ctrl_c_q[CC_PAR_ODD] ^ (^(tx_hold_q & data_mask));
            end else if (os_tick) begin
                tx_smp_q <= tx_bit_end ? 5'h01 : 5'(tx_smp_q + 5'h01);
                if (tx_bit_end && tx_state_q == TX_DATA) begin
                    tx_idx_q <= 4'(tx_idx_q + 4'h1);
                end
            end
        end
    end

    // Transmit-complete: hardware set wins over ack or write-one clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txc_q <= 1'b0;
        end else if (txc_set) begin
            txc_q <= 1'b1;
        end else if (tx_irq_ack || (wr_csa && wr_data[CSA_TXC])) begin
            txc_q <= 1'b0;
        end
    end

    // Software-written control; error bit positions are read-only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            u2x_q <= 1'b0;
            mpcm_q <= 1'b0;
            {rxcie_q, txcie_q, udrie_q, rxen_q, txen_q, size2_q, tx9_q} <= 7'h00;
            ctrl_c_q <= RST_CC;
            baud_q <= RST_BAUD;
        end else begin
            if (wr_csa) begin
                u2x_q <= wr_data[CSA_U2X];
                mpcm_q <= wr_data[CSA_MPCM];
            end
            if (wr_cb) begin
                {rxcie_q, txcie_q, udrie_q, rxen_q, txen_q} <= wr_data[CB_RXCIE:CB_TXEN];
                size2_q <= wr_data[CB_SIZE2];
                tx9_q <= wr_data[CB_TX9];
            end
            if (wr_cc) begin
                ctrl_c_q <= wr_data;
            end
            if (wr_baud) begin
                baud_q <= wr_data;
            end
        end
    end

    // Read mux; a data read also pops the FIFO
    logic rxc;
    logic [7:0] csa_val, cb_val, rd_mux;
    assign rxc = !fifo_empty;
    assign csa_val = {rxc, txc_q, !tx_hold_full_q, head.fe, dor_q, head.upe, u2x_q, mpcm_q};
    assign cb_val = {rxcie_q, txcie_q, udrie_q, rxen_q, txen_q, size2_q, head.ninth, tx9_q};
    assign rd_mux = (addr == OFF_DATA) ? head.data :
                    (addr == OFF_CSA) ? csa_val :
                    (addr == OFF_CB) ? cb_val :
                    (addr == OFF_CC) ? ctrl_c_q :
                    (addr == OFF_BAUD) ? baud_q : 8'h00;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
            rx_irq_q <= 1'b0;
            tx_irq_q <= 1'b0;
        end else begin
            rd_data_q <= rd_en ? rd_mux : 8'h00;
            rx_irq_q <= rxcie_q && global_irq_en && rxc;
            tx_irq_q <= txcie_q && global_irq_en && txc_q;
        end
    end

    a_filter_drop: assert property (
        (rx_done && mpcm_q && !frame_type && !pend_q && !pop && rxen_q) |=> $stable(fifo_empty) && $stable(fifo_full)
    ) else $error("filtered data frame entered receive buffer");

    a_addr_pass: assert property (
        (rx_done && mpcm_q && frame_type && fifo_empty && !pend_q && rxen_q) |=> rxc
    ) else $error("address frame not accepted while filtering");

    a_tx_ignore: assert property (
        (wr_data_win && tx_hold_full_q) |=> $stable(tx_hold_q)
    ) else $error("write to full transmit buffer altered it");

    a_tx_move: assert property (
        (txen_q && tx_hold_full_q && tx_state_q == TX_IDLE && !wr_data_win) |=> !tx_hold_full_q && tx_state_q == TX_START
    ) else $error("buffered data not moved to idle shifter");

    a_rxc_flush: assert property (
        !rxen_q |=> ##1 (!rxc && !dor_q && csa_val[4:2] == 3'b000)
    ) else $error("receiver disable did not flush buffer and errors");

    a_txc_clear: assert property (
        (wr_csa && wr_data[CSA_TXC] && !txc_set) |=> !txc_q
    ) else $error("transmit-complete not cleared by write of one");

    a_irq_gate: assert property (
        rx_irq_q |-> $past(rxcie_q && global_irq_en && rxc)
    ) else $error("receive interrupt raised without all enables");

    a_short_zero: assert property (
        (rx_done && !nine_bit && !size_code[2] && size_code[1:0] != 2'b11) |-> (rx_sh_q[8:7] == 2'b00)
    ) else $error("upper bits of short character not zero");

    a_div_select: assert property (
        (!async_mode || !u2x_q) |-> os_last == OS_NORMAL
    ) else $error("double speed active outside asynchronous mode");

    a_overrun_set: assert property (
        (start_seen && fifo_full && pend_q && rxen_q) |=> dor_q
    ) else $error("overrun not flagged");
endmodule : uart_mp

// >>> sim/serial_node.sv
// Far-side serial node that sends and catches frames
`timescale 1ns/1ps
module serial_node (
    input wire logic clk,
    input wire logic tx_line,
    input wire logic [4:0] per,
    output logic rx_line
);
    logic [7:0] got_q[$];
    initial rx_line = 1'b1;
    task automatic send(input logic [8:0] v, input int nb, input logic stop1);
        rx_line <= 1'b0;
        repeat (per) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            rx_line <= v[i];
            repeat (per) @(posedge clk);
        end
        rx_line <= stop1;
        repeat (per) @(posedge clk);
        rx_line <= 1'b1;
        repeat (per) @(posedge clk);
    endtask : send
    always begin : catch
        logic [7:0] v;
        @(negedge tx_line);
        repeat (per / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (per) @(posedge clk);
            v[i] = tx_line;
        end
        repeat (per) @(posedge clk);
        got_q.push_back(v);
    end
endmodule : serial_node

// >>> sim/uart_buffers_flags_multidrop_tb.sv
// Self-checking bench for the multi-drop serial port
`timescale 1ns/1ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module uart_buffers_flags_multidrop_tb;
    import uart_mp_pkg::*;
    logic clk, rst_n, wr_en, rd_en, rx_line, tx_line_q, global_irq_en, tx_irq_ack, rx_irq_q, tx_irq_q;
    logic [2:0] addr;
    logic [7:0] wr_data, rd_data_q, r, d;
    logic [4:0] per;
    logic [7:0] exp_q[$];
    int err_count, checks, cyc, n, k, t;
    uart_mp u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data_q(rd_data_q), .rx_line(rx_line), .tx_line_q(tx_line_q), .global_irq_en(global_irq_en),
        .tx_irq_ack(tx_irq_ack), .rx_irq_q(rx_irq_q), .tx_irq_q(tx_irq_q));
    serial_node node (.clk(clk), .tx_line(tx_line_q), .per(per), .rx_line(rx_line));
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        v = rd_data_q;
        @(posedge clk);
    endtask : rd
    task automatic poll(input int b);
        r = '0;
        for (int i = 0; i < 300 && r[b] !== 1'b1; i++) rd(OFF_CSA, r);
        `CHK(r[b], 1'b1, "flag wait")
    endtask : poll
    task automatic complete_run;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Tests need about 2000 cycles; ceiling leaves margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        {rst_n, wr_en, rd_en, global_irq_en, tx_irq_ack} = '0;
        addr = '0;
        wr_data = '0;
        per = 5'd16;
        void'($urandom(97));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(OFF_CSA, r);
        `CHK(r, 8'h20, "csa reset")
        wr(OFF_CB, 8'h18);
        // Filter stays on while sending: transmit must not care
        for (k = 0; k < 2; k++) begin
            per <= k ? 5'd8 : 5'd16;
            wr(OFF_CSA, {6'h00, k[0], 1'b1});
            d = 8'($urandom) | 8'h01;
            wr(OFF_DATA, d);
            for (n = 0; n < 40 && tx_line_q !== 1'b0; n++) @(negedge clk);
            for (n = 0; n < 40 && tx_line_q === 1'b0; n++) @(negedge clk);
            `CHK(n, 16 >> k, "start bit length")
            @(posedge clk);
            poll(CSA_TXC);
            `CHK(node.got_q.pop_front(), d, "tx byte")
            wr(OFF_CSA, {2'b01, 4'h0, k[0], 1'b1});
            rd(OFF_CSA, r);
            `CHK(r[CSA_TXC], 1'b0, "txc write one")
        end
        d = 8'($urandom);
        addr <= OFF_DATA;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_data <= ~d;
        @(posedge clk);
        wr_en <= 1'b0;
        poll(CSA_TXC);
        repeat (20) @(posedge clk);
        `CHK(node.got_q.size(), 1, "busy write")
        `CHK(node.got_q.pop_front(), d, "kept write")
        wr(OFF_CB, 8'h58);
        global_irq_en <= 1'b1;
        repeat (2) @(negedge clk);
        `CHK(tx_irq_q, 1'b1, "tx irq")
        @(posedge clk);
        tx_irq_ack <= 1'b1;
        @(posedge clk);
        tx_irq_ack <= 1'b0;
        rd(OFF_CSA, r);
        `CHK({r[CSA_TXC], tx_irq_q}, 2'b00, "tx irq serviced")
        $display("transmit tests done");
        for (k = 0; k < 2; k++) begin
            wr(OFF_CB, k ? 8'h1C : 8'h18);
            for (t = 0; t < 2; t++) begin
                d = 8'($urandom);
                node.send({t[0], d}, 8 + k, k ? 1'b1 : t[0]);
                if (t == 1) exp_q.push_back(d);
            end
            repeat (4) @(posedge clk);
            rd(OFF_CB, r);
            if (k == 1) `CHK(r[1], 1'b1, "ninth bit")
            rd(OFF_DATA, r);
            `CHK(r, exp_q.pop_front(), "address frame")
            rd(OFF_CSA, r);
            `CHK(r[CSA_RXC], 1'b0, "data frame dropped")
        end
        wr(OFF_CSA, 8'h02);
        wr(OFF_CB, 8'h18);
        for (k = 0; k < 4; k++) begin
            wr(OFF_CC, {5'h00, k[1:0], 1'b0});
            d = 8'($urandom);
            node.send({1'b0, d}, 5 + k, k[0]);
            exp_q.push_back(d & (8'hFF >> (3 - k)));
            repeat (4) @(posedge clk);
            rd(OFF_CSA, r);
            `CHK(r[4], ~k[0], "frame error")
            rd(OFF_DATA, r);
            `CHK(r, exp_q.pop_front(), "short char")
        end
        wr(OFF_CC, 8'h26);
        for (k = 0; k < 2; k++) begin
            d = 8'($urandom);
            node.send({^d ^ k[0], d}, 9, 1'b1);
            repeat (4) @(posedge clk);
            rd(OFF_CSA, r);
            `CHK(r[2], k[0], "parity error")
            rd(OFF_DATA, r);
        end
        $display("receive tests done");
        wr(OFF_CC, RST_CC);
        wr(OFF_CB, 8'h98);
        for (k = 0; k < 4; k++) node.send({1'b0, 8'h5A}, 8, 1'b1);
        rd(OFF_CSA, r);
        `CHK({r[CSA_RXC], r[3], rx_irq_q}, 3'b111, "overrun")
        wr(OFF_CB, 8'h08);
        rd(OFF_CSA, r);
        `CHK({r[CSA_RXC], r[4:2], rx_irq_q}, 5'h00, "flushed")
        $display("overrun test done");
        complete_run();
    end
endmodule : uart_buffers_flags_multidrop_tb
